/* File: dsw_map.vh */
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
// Frame geometry
`define DSW_FRAME_BITS 24
`define DSW_CODE_BITS 18
`define DSW_CNT_BITS 5
// Code field position inside the 24-bit shift register (bit 23 arrives first)
`define DSW_CODE_MSB 19
`define DSW_CODE_LSB 2
`define DSW_RSV_HI_POS 21
`define DSW_RSV_LO_POS 20
// Scale codes; zero and midscale serve as power-up codes
`define DSW_ZERO_SCALE 18'h00000
`define DSW_MID_SCALE 18'h20000
`define DSW_FULL_SCALE 18'h3FFFF
// Link timing
`define DSW_MAX_BIT_RATE_MHZ 30
`define DSW_MIN_SEL_HIGH_NS 33
`endif

/* File: dsw_sync3.v */
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module dsw_sync3 (
	input wire clk,
	input wire rst_n,
	input wire in_async,
	input wire rst_val,
	output reg out_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// Shift chain; only s2 reads s1
	always @(posedge clk) begin
		if (!rst_n) begin
			// Chain starts at the pin's idle level, so no false edge follows reset
			s1_q <= rst_val;
			s2_q <= rst_val;
			s3_q <= rst_val;
			out_q <= rst_val;
		end else begin
			s1_q <= in_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end
endmodule // dsw_sync3

/* File: dsw_port.v */
`timescale 1ns/1ns
`include "dsw_map.vh"
// Behaviour
// - Frame select low enables the input shift register to accept bits.
// - One data bit is captured on each serial clock falling edge.
// - Shift register is 24 bits; a complete frame is 24 captured bits.
// - After the 24th bit with select still low, the code loads.
// - Select rising before the 24th edge aborts; code register unchanged.
// - Bit rates up to 30 MHz (limited here by sampling clock).
// - Code register holds an 18-bit straight-binary value.
// - Code is one contiguous binary value, no segmenting.
// - Frame: two ignored, two reserved, 18 code bits MSB first, two ignored.
// - Power-up code is zero or midscale, kept until a valid frame.
module dsw_port #(
	parameter MIDSCALE_START = 0
) (
	input wire clk,
	input wire rst_n,
	input wire sel_n,
	input wire sclk,
	input wire sdin,
	output reg [`DSW_CODE_BITS-1:0] code_q,
	output reg load_q,
	output reg rsv_err_q,
	output reg busy_q
);
	// Sampling clock period; the port can only follow slow links at this rate
	localparam CLK_NS = 100;
	// Least select-high time in sampling cycles, rounded up, at least one
	localparam SEL_HIGH_CYC_RAW = (`DSW_MIN_SEL_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam SEL_HIGH_CYC = (SEL_HIGH_CYC_RAW < 1) ? 1 : SEL_HIGH_CYC_RAW;
	localparam [`DSW_CODE_BITS-1:0] RESET_CODE =
		(MIDSCALE_START != 0) ? `DSW_MID_SCALE : `DSW_ZERO_SCALE;


	// Width of the select-high counter; enough for fifteen sampling cycles
	localparam HOLD_BITS = 4;
	localparam integer HOLD_LAST_INT = SEL_HIGH_CYC - 1;
	localparam [HOLD_BITS-1:0] HOLD_LAST = HOLD_LAST_INT[HOLD_BITS-1:0];

	// Bit count at which the last bit of a frame is taken
	localparam integer LAST_CNT_INT = `DSW_FRAME_BITS - 1;
	localparam [`DSW_CNT_BITS-1:0] LAST_CNT = LAST_CNT_INT[`DSW_CNT_BITS-1:0];

	// Number of pins that cross into the sampling clock
	localparam PIN_COUNT = 3;
	// Idle levels of the pins: data low, serial clock high, select high
	localparam [PIN_COUNT-1:0] PIN_IDLE = 3'h3;

	// Frame states, one-hot
	// Hold: select high, waiting out the least gap between frames
	localparam [3:0] ST_HOLD = 4'h1;
	// Idle: gap met, waiting for select to go low
	localparam [3:0] ST_IDLE = 4'h2;
	// Shift: select low, taking bits on serial clock falls
	localparam [3:0] ST_SHIFT = 4'h4;
	// Done: frame loaded, further falls ignored until select rises
	localparam [3:0] ST_DONE = 4'h8;

	// Filtered pins
	wire [PIN_COUNT-1:0] pin_raw;
	wire [PIN_COUNT-1:0] pin_s;
	wire sel_s;
	wire sclk_s;
	wire din_s;

	// Frame engine state
	reg [3:0] state_q;
	reg [HOLD_BITS-1:0] hold_q;
	reg sclk_prev_q;
	reg [`DSW_FRAME_BITS-1:0] shift_q;
	reg [`DSW_CNT_BITS-1:0] cnt_q;

	// Edge and next shift value
	wire fall;
	wire [`DSW_FRAME_BITS-1:0] shift_d;

	// True when the count names the last bit of a frame
	function is_last;
		input [`DSW_CNT_BITS-1:0] cnt;
		begin
			is_last = (cnt == LAST_CNT);
		end
	endfunction

	// Code field of a whole frame word, taken as one binary value
	function [`DSW_CODE_BITS-1:0] code_of;
		input [`DSW_FRAME_BITS-1:0] word;
		begin
			code_of = word[`DSW_CODE_MSB:`DSW_CODE_LSB];
		end
	endfunction

	// Reserved bits of a whole frame word should be zero
	function rsv_of;
		input [`DSW_FRAME_BITS-1:0] word;
		begin
			rsv_of = word[`DSW_RSV_HI_POS] | word[`DSW_RSV_LO_POS];
		end
	endfunction

	// Pins gathered so that one loop builds their synchronisers
	assign pin_raw = {sdin, sclk, sel_n};

	// Four flip-flops per pin, three stages and the output; a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
			dsw_sync3 u_sync (
				.clk(clk),
				.rst_n(rst_n),
				.in_async(pin_raw[g]),
				.rst_val(PIN_IDLE[g]),
				.out_q(pin_s[g])
			);
		end
	endgenerate

	// Filtered pins by name
	assign sel_s = pin_s[0];
	assign sclk_s = pin_s[1];
	assign din_s = pin_s[2];

	// Falling edge of the filtered serial clock while select is low
	assign fall = sclk_prev_q & ~sclk_s & ~sel_s;

	// Next shift value: oldest bit moves up, newest enters at bit zero
	assign shift_d = {shift_q[`DSW_FRAME_BITS-2:0], din_s};

	// Frame engine: hold, arm, shift, load or abort
	// Data and clock share one sync delay, so the bit beside a fall is the right one.
	// A select rise that lands in the same sampling cycle as the 24th fall
	// can still abort the frame; the limit is the sampling rate.
	always @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_HOLD;
			hold_q <= {HOLD_BITS{1'b0}};
			sclk_prev_q <= 1'b1;
			shift_q <= 24'h000000;
			cnt_q <= 5'h00;
			code_q <= RESET_CODE;
			load_q <= 1'b0;
			rsv_err_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			// Load is a single-cycle pulse
			load_q <= 1'b0;
			case (state_q)
				ST_HOLD: begin
					// Counter and shift register stay clear between frames
					cnt_q <= 5'h00;
					shift_q <= 24'h000000;
					busy_q <= 1'b0;
					if (!sel_s) begin
						// Select fell too soon; wait for a proper gap
						hold_q <= {HOLD_BITS{1'b0}};
					end else if (hold_q == HOLD_LAST) begin
						state_q <= ST_IDLE;
					end else begin
						hold_q <= hold_q + 4'h1;
					end
				end
				ST_IDLE: begin
					cnt_q <= 5'h00;
					shift_q <= 24'h000000;
					if (!sel_s) begin
						// Select low opens the shift register
						state_q <= ST_SHIFT;
						if (fall) begin
							// A fall seen together with select counts as bit one
							shift_q <= shift_d;
							cnt_q <= 5'h01;
							busy_q <= 1'b1;
						end
					end
				end
				ST_SHIFT: begin
					if (sel_s) begin
						// Early rise: partial frame dropped, code untouched
						shift_q <= 24'h000000;
						cnt_q <= 5'h00;
						busy_q <= 1'b0;
						hold_q <= {HOLD_BITS{1'b0}};
						state_q <= ST_HOLD;
					end else if (fall) begin
						shift_q <= shift_d;
						busy_q <= 1'b1;
						if (is_last(cnt_q)) begin
							// 24th bit: straight-binary code loads whole
							code_q <= code_of(shift_d);
							rsv_err_q <= rsv_of(shift_d);
							load_q <= 1'b1;
							busy_q <= 1'b0;
							cnt_q <= 5'h00;
							state_q <= ST_DONE;
						end else begin
							cnt_q <= cnt_q + 5'h01;
						end
					end
				end
				ST_DONE: begin
					// Extra falls in the same low period cause no update
					busy_q <= 1'b0;
					if (sel_s) begin
						shift_q <= 24'h000000;
						cnt_q <= 5'h00;
						hold_q <= {HOLD_BITS{1'b0}};
						state_q <= ST_HOLD;
					end
				end
				default: begin
					// Lost state: drop any frame and start over
					shift_q <= 24'h000000;
					cnt_q <= 5'h00;
					busy_q <= 1'b0;
					hold_q <= {HOLD_BITS{1'b0}};
					state_q <= ST_HOLD;
				end
			endcase
		end
	end
endmodule // dsw_port

/* File: dsw_port_props.sv */
`timescale 1ns/1ns
module dsw_port_props(input logic clk, rst_n, sel_n, sclk, sdin, load_q, rsv_err_q, busy_q,
	input logic [17:0] code_q);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
a_load_pulse: assert property (load_q |=> !load_q) else $error("pulse");
a_code_hold: assert property (!load_q |-> $stable(code_q)) else $error("code");
a_rsv_hold: assert property (!load_q |-> $stable(rsv_err_q)) else $error("rsv");
a_idle_load: assert property (sel_n [*8] |-> !load_q) else $error("idle");
a_idle_busy: assert property (sel_n [*8] |-> !busy_q) else $error("busy");
a_quiet_load: assert property ($stable(sclk) [*8] |-> !load_q) else $error("edge");
a_busy_sel: assert property ($rose(busy_q) |-> !sel_n) else $error("sel");
a_load_sel: assert property (load_q |-> !$past(sel_n, 4)) else $error("abort");
cover property (load_q);
cover property ($rose(rsv_err_q));
cover property ($fell(busy_q) && !load_q);
endmodule // dsw_port_props
bind dsw_port dsw_port_props P(.*);

/* File: dsw_host.sv */
`timescale 1ns/1ns
module dsw_host(output logic sel_n = 1, sclk = 1, sdin = 0);
// Sends n falls MSB first; clock parks high between frames
task send(input logic [23:0] w, input int n);
	sel_n = 0;
	for (int i = 0; i < n; i++) begin
		#400 sdin = w[23 - i % 24];
		#400 sclk = 0;
		#400 sclk = 1;
	end
	#1000 sel_n = 1;
	sdin = ~sdin;
	#800;
endtask
endmodule // dsw_host

/* File: dsw_port_tb.sv */
`timescale 1ns/1ns
module dsw_port_tb;
logic clk = 0, rst_n = 0, mr = 0;
logic [17:0] m = 0;
wire sel_n, sclk, sdin, load_q, rsv_err_q, busy_q;
wire [17:0] code_q;
int bad_count = 0, n_checks = 0, seed = 32'h074e, loads = 0;
initial forever #50 clk = ~clk;
always @(posedge clk) loads += load_q;
dsw_host H(.*);
dsw_port DUT(.*);
task check(input string nm, input logic [17:0] s, e);
	n_checks++;
	if (s !== e) begin
		bad_count++;
		$display("MISMATCH %s exp %h seen %h", nm, e, s);
	end
endtask
task stop_test;
	$display("checks %0d bad %0d", n_checks, bad_count);
	if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
// Model keeps code and reserved flag of the last whole frame
task frame(input logic [17:0] c, input logic [1:0] r, input int n);
	loads = 0;
	H.send({2'($random(seed)), r, c, 2'($random(seed))}, n);
	if (n > 23) {mr, m} = {|r, c};
	check("load", 18'(loads), 18'(n > 23));
	check("code", code_q, m);
	check("rsv", 18'(rsv_err_q), 18'(mr));
	$display("frame %0d done", n);
endtask
initial begin
	repeat (10) @(negedge clk);
	rst_n = 1;
	#1000 check("reset", code_q, 0);
	frame(18'h3FFFF, 0, 24);
	frame(18'h1FFFF, 0, 24);
	frame(18'h20000, 3, 24);
	frame(18'h00001, 0, 23);
	frame(18'h00002, 1, 30);
	repeat (3) frame(18'($random(seed)), 2, 24);
	stop_test;
end
initial #2000000 begin
	bad_count++;
	stop_test;
end
endmodule // dsw_port_tb
